/* design/cet_pkg.sv */
// Package: constants and types for the compare event trigger block
package cet_pkg;

    // ************************************************************
    // Register byte offsets on the APB
    // ************************************************************
    localparam logic [7:0] OFF_COMMAND = 8'h00;
    localparam logic [7:0] OFF_DATA_LO = 8'h04;
    localparam logic [7:0] OFF_DATA_HI = 8'h08;
    localparam logic [7:0] OFF_MODE_ONE = 8'h0c;
    localparam logic [7:0] OFF_STATUS_ONE = 8'h10;

    // ************************************************************
    // Command codes and command word fields
    // ************************************************************
    localparam logic [7:0] CMD_MR_LOAD_BASE = 8'h10;
    localparam logic [7:0] CMD_TIMER_LOAD = 8'h16;
    localparam logic [7:0] CMD_TIMER_START = 8'h73;
    localparam logic [7:0] CMD_NOP = 8'h1f;
    localparam logic [7:0] CMD_MR_MODE = 8'h20;
    localparam logic [7:0] CMD_SYNC_BASE = 8'h26;
    localparam logic [3:0] CMD_SYNC_EN_HI = 4'h8;
    localparam logic [3:0] CMD_SYNC_DIS_HI = 4'h9;
    localparam int CMD_AXIS_BIT = 8;

    // ************************************************************
    // Field layouts and codes
    // ************************************************************
    localparam int NUM_MR = 4;
    localparam int MR_MODE_BITS = 4;
    localparam logic [3:0] FACTOR_MR_TRUE = 4'h1;
    localparam logic [1:0] COND_GE = 2'h0;
    localparam logic [1:0] COND_GT = 2'h1;
    localparam logic [1:0] COND_EQ = 2'h2;
    localparam logic [1:0] OBJ_LP = 2'h0;
    localparam logic [1:0] OBJ_RP = 2'h1;
    localparam logic [1:0] OBJ_CV = 2'h2;

    // ************************************************************
    // Timing: the timer counts whole microseconds
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int TIMER_UNIT_NS = 1000;
    localparam int TIMER_DIV = TIMER_UNIT_NS / CLK_PERIOD_NS;

    // Per reference register compare mode
    typedef struct packed {
        logic [1:0] cond;
        logic [1:0] obj;
    } cet_mr_mode_t;

    // Per action set configuration
    typedef struct packed {
        logic rpt;
        logic [5:0] action;
        logic [3:0] factor;
    } cet_sync_cfg_t;

    // Live quantities from the axis
    typedef struct packed {
        logic [31:0] lp;
        logic [31:0] rp;
        logic [31:0] cv;
    } cet_counts_t;

endpackage

/* design/cet_compare_event_trigger.sv */
// Module: compare event trigger with APB registers and action set events
// Summary of operation
// - Compare turning true fires its action set
// - Already true at enable does not fire
// - Falling false then true fires again
// - Reference n drives action set n, cmds 26h-29h
// - Set command also holds action and repeat
// - Compare turning true raises enabled interrupt
// - Already true at enable raises nothing
// - Falling then rising raises interrupt again
// - Mode one bits 0-3 enable interrupts
// - Status one bits 0-3 show factors
// - Condition field: ge, gt, eq, lt
// - Object field: LP, RP, CV, timer
// - Compare pin high while result true
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module cet_compare_event_trigger #(
    parameter int TIMER_DIV = cet_pkg::TIMER_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cet_pkg::cet_counts_t counts,
    output logic [3:0] compare_output_pins,
    output logic [3:0] sync_fire,
    output cet_pkg::cet_sync_cfg_t [3:0] sync_cfg,
    output logic irq
);

    // ************************************************************
    // APB decode
    // ************************************************************
    logic access;
    logic wr_en;
    logic rd_en;
    logic sel_cmd;
    logic sel_lo;
    logic sel_hi;
    logic sel_mode;
    logic sel_stat;
    logic mapped;

    // Zero wait state slave; unmapped addresses answer with pslverr
    assign access = psel & penable;
    assign wr_en = access & pwrite;
    assign rd_en = access & ~pwrite;
    assign sel_cmd = paddr == cet_pkg::OFF_COMMAND;
    assign sel_lo = paddr == cet_pkg::OFF_DATA_LO;
    assign sel_hi = paddr == cet_pkg::OFF_DATA_HI;
    assign sel_mode = paddr == cet_pkg::OFF_MODE_ONE;
    assign sel_stat = paddr == cet_pkg::OFF_STATUS_ONE;
    assign mapped = sel_cmd | sel_lo | sel_hi | sel_mode | sel_stat;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // ************************************************************
    // Command decode
    // ************************************************************
    logic cmd_wr;
    logic [7:0] code;
    logic axis_hit;
    logic do_mr_load;
    logic do_tmr_load;
    logic do_tmr_start;
    logic do_nop;
    logic do_mode;
    logic do_sync_cfg;
    logic do_sync_en;
    logic do_sync_dis;
    logic [1:0] mr_idx;
    logic [1:0] sync_idx;
    logic [31:0] data_word;

    // Commands other than NOP act only on this axis, chosen by the axis select bit
    assign cmd_wr = wr_en & sel_cmd;
    assign code = pwdata[7:0];
    assign axis_hit = pwdata[cet_pkg::CMD_AXIS_BIT];
    assign mr_idx = 2'(code - cet_pkg::CMD_MR_LOAD_BASE);
    assign sync_idx = 2'(code - cet_pkg::CMD_SYNC_BASE);
    assign do_mr_load = cmd_wr & axis_hit
        & (code[7:2] == cet_pkg::CMD_MR_LOAD_BASE[7:2]);
    assign do_tmr_load = cmd_wr & axis_hit
        & (code == cet_pkg::CMD_TIMER_LOAD);
    assign do_tmr_start = cmd_wr & axis_hit
        & (code == cet_pkg::CMD_TIMER_START);
    assign do_nop = cmd_wr & (code == cet_pkg::CMD_NOP);
    assign do_mode = cmd_wr & axis_hit & (code == cet_pkg::CMD_MR_MODE);
    assign do_sync_cfg = cmd_wr & axis_hit
        & (code >= cet_pkg::CMD_SYNC_BASE)
        & (code <= cet_pkg::CMD_SYNC_BASE + 8'h03);
    assign do_sync_en = cmd_wr & axis_hit
        & (code[7:4] == cet_pkg::CMD_SYNC_EN_HI) & (code[3:0] != 4'h0);
    assign do_sync_dis = cmd_wr & axis_hit
        & (code[7:4] == cet_pkg::CMD_SYNC_DIS_HI) & (code[3:0] != 4'h0);

    // ************************************************************
    // Data words, axis select and mode one
    // ************************************************************
    logic [15:0] data_lo_q;
    logic [15:0] data_hi_q;
    logic axis_sel_q;
    logic [3:0] irq_en_q;

    assign data_word = {data_hi_q, data_lo_q};

    // Mode one only lands when the axis was picked by the last NOP
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_lo_q <= 16'h0000;
            data_hi_q <= 16'h0000;
            axis_sel_q <= 1'b0;
            irq_en_q <= 4'h0;
        end else begin
            if (wr_en && sel_lo) data_lo_q <= pwdata[15:0];
            if (wr_en && sel_hi) data_hi_q <= pwdata[15:0];
            if (do_nop) axis_sel_q <= axis_hit;
            if (wr_en && sel_mode && axis_sel_q) irq_en_q <= pwdata[3:0];
        end
    end

    // ************************************************************
    // Microsecond timer
    // ************************************************************
    logic [31:0] tmr_q;
    logic [31:0] tmr_lim_q;
    logic [15:0] div_q;
    logic tmr_run_q;
    logic tick;

    assign tick = tmr_run_q & (div_q == 16'(TIMER_DIV - 1));

    // one count per microsecond, stops at the loaded value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_q <= 32'h0000_0000;
            tmr_lim_q <= 32'h0000_0000;
            div_q <= 16'h0000;
            tmr_run_q <= 1'b0;
        end else begin
            if (do_tmr_load) tmr_lim_q <= data_word;
            if (do_tmr_start) begin
                tmr_q <= 32'h0000_0000;
                div_q <= 16'h0000;
                tmr_run_q <= 1'b1;
            end else if (tick) begin
                div_q <= 16'h0000;
                tmr_q <= tmr_q + 32'h0000_0001;
                if (tmr_q + 32'h0000_0001 == tmr_lim_q) tmr_run_q <= 1'b0;
            end else if (tmr_run_q) begin
                div_q <= div_q + 16'h0001;
            end
        end
    end

    // ************************************************************
    // Per reference register compare, edge and events
    // ************************************************************
    logic [3:0] cur;
    logic [3:0] prev_q;
    logic [3:0] rise;
    logic [3:0] fire_d;
    logic [3:0] fire_q;
    logic [3:0] irq_set;
    logic [3:0] sync_en_q;
    logic [3:0] factor_q;
    logic stat_rd;

    assign stat_rd = rd_en & sel_stat;

    genvar g;
    generate
        for (g = 0; g < cet_pkg::NUM_MR; g++) begin : g_mr
            logic [31:0] ref_q;
            cet_pkg::cet_mr_mode_t mode_q;
            cet_pkg::cet_sync_cfg_t cfg_q;
            logic signed [31:0] obj_val;
            logic signed [31:0] ref_val;

            assign obj_val = (mode_q.obj == cet_pkg::OBJ_LP) ? counts.lp
                : (mode_q.obj == cet_pkg::OBJ_RP) ? counts.rp
                : (mode_q.obj == cet_pkg::OBJ_CV) ? counts.cv : tmr_q;
            assign ref_val = ref_q;
            assign cur[g] = (mode_q.cond == cet_pkg::COND_GE)
                ? (obj_val >= ref_val)
                : (mode_q.cond == cet_pkg::COND_GT) ? (obj_val > ref_val)
                : (mode_q.cond == cet_pkg::COND_EQ) ? (obj_val == ref_val)
                : (obj_val < ref_val);
            // rise only after a false cycle
            assign rise[g] = cur[g] & ~prev_q[g];
            // factor 01h, set enabled, fresh edge
            assign fire_d[g] = rise[g] & sync_en_q[g]
                & (cfg_q.factor == cet_pkg::FACTOR_MR_TRUE);
            assign irq_set[g] = rise[g] & irq_en_q[g];
            assign sync_cfg[g] = cfg_q;

            // Reference, mode and action set configuration
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ref_q <= 32'h0000_0000;
                    mode_q <= '0;
                    cfg_q <= '0;
                end else begin
                    if (do_mr_load && mr_idx == 2'(g)) ref_q <= data_word;
                    if (do_mode) begin
                        mode_q <= data_lo_q[g*4 +: 4];
                    end
                    if (do_sync_cfg && sync_idx == 2'(g)) begin
                        cfg_q <= data_lo_q[10:0];
                    end
                end
            end

            // Enable, previous result, event pulse and factor flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_en_q[g] <= 1'b0;
                    prev_q[g] <= 1'b0;
                    fire_q[g] <= 1'b0;
                    factor_q[g] <= 1'b0;
                end else begin
                    prev_q[g] <= cur[g];
                    fire_q[g] <= fire_d[g];
                    // enable mask in low nibble, one-shot unless rpt
                    if (do_sync_en && code[g]) begin
                        sync_en_q[g] <= 1'b1;
                    end else if (do_sync_dis && code[g]) begin
                        sync_en_q[g] <= 1'b0;
                    end else if (fire_d[g] && !cfg_q.rpt) begin
                        sync_en_q[g] <= 1'b0;
                    end
                    // sticky flag; a new event beats the read clear
                    if (irq_set[g]) factor_q[g] <= 1'b1;
                    else if (stat_rd) factor_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Outputs and read data
    // ************************************************************
    // pin follows the registered result
    assign compare_output_pins = prev_q;
    assign sync_fire = fire_q;
    assign irq = |factor_q;

    // Status one: factors, registered results, set enables
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en && sel_lo) prdata = {16'h0000, data_lo_q};
        if (rd_en && sel_hi) prdata = {16'h0000, data_hi_q};
        if (stat_rd) prdata = {20'h00000, sync_en_q, prev_q, factor_q};
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Armed set with the compare factor, seeing a fresh rise
    sequence s_armed_rise(int i);
        sync_en_q[i] && !prev_q[i] && cur[i]
            && sync_cfg[i].factor == cet_pkg::FACTOR_MR_TRUE;
    endsequence

    sequence s_true_stays(int i);
        prev_q[i] && cur[i];
    endsequence

    sync_fires_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_armed_rise(2) |=> sync_fire[2] ##1 !sync_fire[2])
        else $error("Set two did not fire one pulse on rise");

    no_stale_fire_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_true_stays(0) |=> !sync_fire[0])
        else $error("Set zero fired without a fresh edge");

    refire_again_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cur[2] ##1 s_armed_rise(2) |=> sync_fire[2])
        else $error("Set two did not fire again after falling");

    set_mapping_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        do_sync_cfg && sync_idx == 2'd3
        |=> sync_cfg[3] == 11'($past(data_lo_q)))
        else $error("Setting command missed its set");

    irq_raise_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rise[2] && irq_en_q[2] |=> factor_q[2] && irq)
        else $error("Enabled rise did not raise interrupt");

    irq_quiet_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !factor_q[0] && !irq_set[0] |=> !factor_q[0])
        else $error("Factor set without an enabled rise");

    irq_masked_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rise[1] && !irq_en_q[1] && !factor_q[1] |=> !factor_q[1])
        else $error("Masked reference raised a factor");

    flag_wins_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_set[2] && stat_rd |=> factor_q[2])
        else $error("Read clear beat a new event");

    // Cycles since timer start or last tick; the divider is a parameter,
    // so a fixed repetition count cannot express the spacing
    logic [15:0] gap_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 16'h0000;
        end else if (do_tmr_start || tick) begin
            gap_q <= 16'h0000;
        end else if (gap_q != 16'hffff) begin
            gap_q <= gap_q + 16'h0001;
        end
    end

    timer_unit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        tick |-> gap_q >= 16'(TIMER_DIV - 1))
        else $error("Timer ticked faster than one per microsecond");

    pin_follows_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur[3] |=> compare_output_pins[3])
        else $error("Compare pin not high on true result");

endmodule

`default_nettype wire

/* sim/cet_host_model.sv */
// Host model: APB master that issues axis commands to the block
`timescale 1ns/1ps
`default_nettype none

module cet_host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    // ****************************************
    // Bus cycle and command helpers
    // ****************************************
    // Idle bus from time zero, so reset never sees a request
    initial begin
        psel = 1'b0;
        penable = 1'b0;
    end

    // One transfer; the wait is bounded so a dead slave ends the run
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 16) begin
            tb_compare_event_trigger.n_mismatch++;
            tb_compare_event_trigger.test_done();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q,
            output logic e);
        xfer(1'b0, a, 32'h0, q, e);
    endtask

    // Command word, caller supplies the axis select bit
    task automatic cmd(input logic [15:0] c);
        wr(cet_pkg::OFF_COMMAND, {16'h0, c});
    endtask

    // low word, high word, then command
    task automatic ld32(input logic [15:0] c, input logic [31:0] v);
        wr(cet_pkg::OFF_DATA_LO, {16'h0, v[15:0]});
        wr(cet_pkg::OFF_DATA_HI, {16'h0, v[31:16]});
        cmd(c);
    endtask

    task automatic ld16(input logic [15:0] c, input logic [15:0] v);
        wr(cet_pkg::OFF_DATA_LO, {16'h0, v});
        cmd(c);
    endtask

    task automatic irq_en(input logic [3:0] m);
        cmd(16'h011f);
        wr(cet_pkg::OFF_MODE_ONE, {28'h0, m});
    endtask
endmodule
`default_nettype wire

/* sim/tb_compare_event_trigger.sv */
// Testbench for the compare event trigger block
`timescale 1ns/1ps
`default_nettype none

module tb_compare_event_trigger;
    // Short timer tick keeps the timer scenario brief
    localparam int DIV = 2;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, base;
    logic [3:0] pins, fire;
    logic [3:0][7:0] fcnt;
    cet_pkg::cet_counts_t counts;
    cet_pkg::cet_sync_cfg_t [3:0] cfg;
    int n_mismatch, tests_run;

    cet_compare_event_trigger #(.TIMER_DIV(DIV)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .counts(counts), .compare_output_pins(pins),
        .sync_fire(fire), .sync_cfg(cfg), .irq(irq));
    cet_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    // ****************************************
    // Clock, pulse counting and helpers
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Count action pulses; a stretched pulse shows as an extra count
    always @(posedge pclk) begin
        for (int k = 0; k < 4; k++) begin
            if (fire[k] === 1'b1) begin
                fcnt[k] = fcnt[k] + 8'h01;
            end
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // New axis quantities, then time for compare, edge and flags
    task automatic setc(input logic [31:0] l, input logic [31:0] r,
            input logic [31:0] v);
        @(posedge pclk);
        counts <= {l, r, v};
        repeat (4) @(posedge pclk);
    endtask

    task automatic t_regs();
        // Zero object meets zero reference under at least: results high
        host.rd(cet_pkg::OFF_STATUS_ONE, rdat, err);
        chk(rdat, 32'h0000_00f0);
        host.wr(cet_pkg::OFF_DATA_LO, 32'h1234_a5c3);
        host.rd(cet_pkg::OFF_DATA_LO, rdat, err);
        chk(rdat, 32'h0000_a5c3);
        host.rd(8'h14, rdat, err);
        chk({err, rdat[30:0]}, 32'h80000000);
    endtask

    task automatic t_cond();
        logic exp;
        host.ld32(16'h0110, 32'h32);
        for (int c = 0; c < 4; c++) begin
            host.ld16(16'h0120, {12'h0, c[1:0], 2'h0});
            for (int d = 0; d < 3; d++) begin
                setc(32'h31 + d, 32'h0, 32'h0);
                case (c)
                    0: exp = (d >= 1);
                    1: exp = (d == 2);
                    2: exp = (d == 1);
                    default: exp = (d == 0);
                endcase
                chk({31'h0, pins[0]}, {31'h0, exp});
            end
        end
    endtask

    task automatic t_obj();
        for (int k = 0; k < 3; k++) begin
            host.ld16(16'h0120, {12'h0, cet_pkg::COND_EQ, k[1:0]});
            setc(k == 0 ? 32'h32 : 32'h7, k == 1 ? 32'h32 : 32'h7,
                k == 2 ? 32'h32 : 32'h7);
            chk({31'h0, pins[0]}, 32'h1);
        end
    endtask

    task automatic t_sync();
        for (int n = 0; n < 4; n++) begin
            host.ld32(16'h0110 + n[15:0], 32'h64);
            host.ld16(16'h0126 + n[15:0], 16'h04a1);
            // Config lands at the access edge; look one edge later
            @(posedge pclk);
            chk({21'h0, cfg[n]}, 32'h4a1);
        end
        host.ld16(16'h0120, 16'h0);
        setc(32'h0, 32'h0, 32'h0);
        host.cmd(16'h018f);
        base = fcnt;
        setc(32'h64, 32'h0, 32'h0);
        chk(fcnt, base + 32'h01010101);
        chk({28'h0, pins}, 32'hf);
        host.cmd(16'h019f);
        host.cmd(16'h0184);
        repeat (4) @(posedge pclk);
        chk(fcnt, base + 32'h01010101);
        setc(32'h0, 32'h0, 32'h0);
        setc(32'h64, 32'h0, 32'h0);
        chk(fcnt, base + 32'h01020101);
    endtask

    task automatic t_irq();
        host.rd(cet_pkg::OFF_STATUS_ONE, rdat, err);
        setc(32'h0, 32'h0, 32'h0);
        host.irq_en(4'h4);
        setc(32'h64, 32'h0, 32'h0);
        chk({31'h0, irq}, 32'h1);
        host.rd(cet_pkg::OFF_STATUS_ONE, rdat, err);
        chk({28'h0, rdat[3:0]}, 32'h4);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        host.irq_en(4'h0);
        setc(32'h0, 32'h0, 32'h0);
        setc(32'h64, 32'h0, 32'h0);
        host.irq_en(4'h4);
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        setc(32'h0, 32'h0, 32'h0);
        setc(32'h64, 32'h0, 32'h0);
        chk({31'h0, irq}, 32'h1);
        // Status read meets a new rise in its access cycle: set must win
        setc(32'h0, 32'h0, 32'h0);
        host.rd(cet_pkg::OFF_STATUS_ONE, rdat, err);
        fork
            host.rd(cet_pkg::OFF_STATUS_ONE, rdat, err);
            begin
                repeat (2) @(posedge pclk);
                counts <= {32'h64, 32'h0, 32'h0};
            end
        join
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
    endtask

    // Timer compare: reference 3 at five ticks, timer object, at least
    task automatic t_timer();
        int n;
        host.ld32(16'h0116, 32'h3e8);
        host.ld32(16'h0113, 32'h5);
        host.ld16(16'h0120, 16'h3000);
        host.cmd(16'h0173);
        n = 0;
        while (pins[3] !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, n >= 5 * DIV - 1 && n <= 5 * DIV + 3}, 32'h1);
        if (n >= 40) begin
            test_done();
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Reset for three cycles, then every scenario in turn
    initial begin
        presetn = 1'b0;
        counts = '0;
        fcnt = '0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_cond();
        t_obj();
        t_sync();
        t_irq();
        t_timer();
        test_done();
    end
endmodule
`default_nettype wire
